// >>> pkg/mcc_pkg.sv
/*
 * Constants, encodings and the state type of the main clock controller.
 * Assumes a single system clock and a synchronous, active-high reset.
 */
`default_nettype none

package mcc_pkg;

	// ************************************************************
	// Register offsets.
	// ************************************************************
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h01;
	localparam logic [7:0] OFS_LOCK = 8'h02;
	localparam logic [7:0] OFS_STATUS = 8'h03;
	localparam logic [7:0] OFS_FAST_CTRL = 8'h10;
	localparam logic [7:0] OFS_CAL_A = 8'h11;
	localparam logic [7:0] OFS_CAL_B = 8'h12;
	localparam logic [7:0] OFS_LP_CTRL = 8'h18;
	localparam logic [7:0] OFS_XO_CTRL = 8'h1c;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int BIT_CLOCK_OUTPUT_PIN = 7;
	localparam int BIT_PEN = 0;
	localparam int BIT_RSTDBY = 1;
	localparam int BIT_XO_EN = 0;
	localparam int BIT_XO_SEL = 2;
	localparam int BIT_CAL_LOCK = 7;
	localparam int BIT_EXT_S = 7;
	localparam int BIT_XO_S = 6;
	localparam int BIT_LP_S = 5;
	localparam int BIT_FAST_S = 4;
	localparam int BIT_CHG = 0;

	// ************************************************************
	// Sources, sleep modes and reset values.
	// ************************************************************
	localparam logic [1:0] SRC_FAST = 2'h0;
	localparam logic [1:0] SRC_LP = 2'h1;
	localparam logic [1:0] SRC_XO = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	localparam logic [1:0] MODE_ACTIVE = 2'h0;
	localparam logic [1:0] MODE_IDLE = 2'h1;
	localparam logic [1:0] MODE_STANDBY = 2'h2;
	localparam logic [1:0] MODE_PDOWN = 2'h3;
	localparam logic [3:0] RST_PDIV = 4'h8;
	localparam logic RST_PEN = 1'h1;
	localparam logic [6:0] RST_DIV = 7'h06;

	// ************************************************************
	// Timing counts.
	// ************************************************************
	localparam logic [2:0] FAST_EXTRA_CYC = 3'h4;
	localparam logic [1:0] EXT_START_EDGES = 2'h2;
	localparam logic [2:0] GUARD_WINDOW = 3'h4;

	typedef enum logic [1:0] {
		SW_IDLE = 2'b01,
		SW_BUSY = 2'b10
	} mcc_sw_t;

	typedef struct packed {
		mcc_sw_t sw;
		logic [1:0] sel;
		logic [1:0] cur;
		logic clock_output_pin;
		logic [3:0] pdiv;
		logic pen;
		logic calibration_lock_enable;
		logic fast_rstdby;
		logic lp_rstdby;
		logic xo_rstdby;
		logic xo_sel;
		logic [1:0] xo_csut;
		logic xo_en;
		logic [5:0] cal;
		logic [3:0] temp;
		logic freq20;
		logic lock_fuse;
		logic [2:0] guard;
		logic [2:0] fast_cnt;
		logic fast_gate;
		logic [1:0] ext_cnt;
		logic [6:0] div_cnt;
		logic [6:0] div_act;
		logic per_tick;
		logic clock_output_pin_on;
		logic [3:0] osc_en;
		logic main_run;
		logic [7:0] rdata;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic ext_prev;
	} mcc_state_t;

endpackage

`default_nettype wire

// >>> core/mcc_main_clock_controller.sv
/*
 * Main clock controller: source requests, safe main source switching,
 * peripheral prescaler, sleep gating, fuse-loaded calibration and the
 * configuration change guard.
 * Assumes the CPU pulses the guard key input, oscillator ready and the
 * external clock level arrive asynchronously, and every other input is
 * driven on clk_sys_in.
 */
// The placing of the registers and the strobed register port are this design's own decisions.
//
// Behaviour
// [RULE_01] Requested sources enabled, unused sources off.
// [RULE_02] Each request routed to its selected source.
// [RULE_03] Run-in-standby keeps oscillator on except power-down.
// [RULE_04] Main clock runs active/idle; standby on demand.
// [RULE_05] Power-down stops main clock after NVM done.
// [RULE_06] Software selects main source; unsafe switch blocked.
// [RULE_07] External switch waits edges; selection then frozen.
// [RULE_08] Changing flag set during source switch.
// [RULE_09] Per-source stable flags in status register.
// [RULE_10] Prescaler offers twelve settings, 1x to 64x.
// [RULE_11] Peripheral tick prescaled; CPU clock undivided.
// [RULE_12] Select and prescaler writes need unlock.
// [RULE_13] Reset selects fast oscillator, divide by six.
// [RULE_14] Frequency fuse picks 16 or 20 MHz.
// [RULE_15] Calibration fields loaded from fuses at reset.
// [RULE_16] Lock fuse blocks calibration changes.
// [RULE_17] Lock enable blocks calibration while fast main.
// [RULE_18] Calibration writes need unlock.
// [RULE_19] Fast output held until ready plus four.
// [RULE_20] Software lowers clock before recalibration.
// [RULE_21] Crystal unused until its enable is set.
// [RULE_22] Timer, watchdog, sampled brown-out request clocks.
// [RULE_23] Software changes timer sources only when disabled.
// [RULE_24] Protected write only within four instructions.
// [RULE_25] Unguarded protected write leaves register unchanged.
// [RULE_26] External input needs two edges to start.
// [RULE_27] Flag clears when mux switched; switch clean.
// [RULE_28] New divisor applied at a tick boundary.
`default_nettype none

module mcc_main_clock_controller (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic guard_key_in,
	input wire logic [1:0] sleep_mode_in,
	input wire logic main_req_in,
	input wire logic nvm_busy_in,
	input wire logic rtc_enable_in,
	input wire logic [1:0] rtc_src_in,
	input wire logic wdt_enable_in,
	input wire logic bod_sampled_in,
	input wire logic tcd_enable_in,
	input wire logic tcd_src_in,
	input wire logic fuse_freq20_in,
	input wire logic fuse_osc_lock_in,
	input wire logic [5:0] fuse_cal_in,
	input wire logic [3:0] fuse_temp_in,
	input wire logic [2:0] osc_ready_in,
	input wire logic ext_clk_in,
	output logic [3:0] osc_en_out,
	output logic fast_gate_out,
	output logic [1:0] main_src_out,
	output logic main_run_out,
	output logic per_tick_out,
	output logic clock_output_pin_en_out,
	output logic freq20_out,
	output logic [5:0] cal_out,
	output logic [3:0] temp_out
);

	mcc_pkg::mcc_state_t q, d;

	// ************************************************************
	// Prescaler setting to divisor.
	// ************************************************************
	function automatic logic [6:0] div_of(input logic pen,
		input logic [3:0] pdiv);
		logic [6:0] r;
		r = 7'h01;
		if (pen) begin
			case (pdiv)
				4'h0: r = 7'h02;
				4'h1: r = 7'h04;
				4'h2: r = 7'h08;
				4'h3: r = 7'h10;
				4'h4: r = 7'h20;
				4'h5: r = 7'h40;
				4'h8: r = 7'h06;
				4'h9: r = 7'h0a;
				4'ha: r = 7'h0c;
				4'hb: r = 7'h18;
				4'hc: r = 7'h30;
				default: r = 7'h01;
			endcase
		end
		return r;
	endfunction

	logic guard_open, wr_a, wr_b, cal_locked, sw_ok;
	logic [3:0] src_ok, per_req, main_need, keep;
	logic [6:0] div_new;

	// ************************************************************
	// Next-state logic.
	// ************************************************************
	always_comb begin
		d = q;
		guard_open = (q.guard != 3'h0);
		// Protected registers only change inside the guard window.
		wr_a = wr_in && guard_open; // [RULE_12] [RULE_24] [RULE_25]
		wr_b = wr_in && guard_open; // [RULE_18]
		cal_locked = q.lock_fuse // [RULE_16]
			|| (q.calibration_lock_enable && q.cur == mcc_pkg::SRC_FAST); // [RULE_17]
		src_ok[mcc_pkg::SRC_FAST] = (q.fast_cnt == mcc_pkg::FAST_EXTRA_CYC);
		src_ok[mcc_pkg::SRC_LP] = q.sync2[1];
		src_ok[mcc_pkg::SRC_XO] = q.sync2[2] && q.xo_en;
		src_ok[mcc_pkg::SRC_EXT] = (q.ext_cnt == mcc_pkg::EXT_START_EDGES);
		sw_ok = src_ok[q.sel];
		div_new = div_of(q.pen, q.pdiv);

		// Synchronisers for the asynchronous inputs.
		d.sync1 = {ext_clk_in, osc_ready_in};
		d.sync2 = q.sync1;
		d.ext_prev = q.sync2[3];

		// Guard window opened by the key, closed after its count.
		if (guard_key_in) begin
			d.guard = mcc_pkg::GUARD_WINDOW; // [RULE_24]
		end else if (guard_open) begin
			d.guard = q.guard - 3'h1;
		end

		// Register writes.
		if (wr_a && addr_in == mcc_pkg::OFS_CTRL_A) begin
			d.clock_output_pin = wdata_in[mcc_pkg::BIT_CLOCK_OUTPUT_PIN];
			// Selection frozen while a switch is pending.
			if (q.sw == mcc_pkg::SW_IDLE && wdata_in[1:0] != q.cur) begin
				d.sel = wdata_in[1:0]; // [RULE_06] [RULE_07]
				d.sw = mcc_pkg::SW_BUSY; // [RULE_08]
			end
		end
		if (wr_a && addr_in == mcc_pkg::OFS_CTRL_B) begin
			d.pdiv = wdata_in[4:1]; // [RULE_10]
			d.pen = wdata_in[mcc_pkg::BIT_PEN];
		end
		if (wr_a && addr_in == mcc_pkg::OFS_LOCK) begin
			d.calibration_lock_enable = wdata_in[0];
		end
		if (wr_a && addr_in == mcc_pkg::OFS_FAST_CTRL) begin
			d.fast_rstdby = wdata_in[mcc_pkg::BIT_RSTDBY];
		end
		if (wr_a && addr_in == mcc_pkg::OFS_LP_CTRL) begin
			d.lp_rstdby = wdata_in[mcc_pkg::BIT_RSTDBY];
		end
		if (wr_a && addr_in == mcc_pkg::OFS_XO_CTRL) begin
			d.xo_csut = wdata_in[5:4];
			d.xo_sel = wdata_in[mcc_pkg::BIT_XO_SEL];
			d.xo_rstdby = wdata_in[mcc_pkg::BIT_RSTDBY];
			d.xo_en = wdata_in[mcc_pkg::BIT_XO_EN];
		end
		if (wr_b && !cal_locked && addr_in == mcc_pkg::OFS_CAL_A) begin
			d.cal = wdata_in[5:0]; // [RULE_16] [RULE_17] [RULE_18]
		end
		if (wr_b && !cal_locked && addr_in == mcc_pkg::OFS_CAL_B) begin
			d.temp = wdata_in[3:0]; // [RULE_18]
		end

		// Source switch completes only once the target is ready.
		case (q.sw)
			mcc_pkg::SW_IDLE: begin
				d.cur = q.cur;
			end
			mcc_pkg::SW_BUSY: begin
				if (sw_ok) begin
					d.cur = q.sel; // [RULE_07] [RULE_27]
					d.sw = mcc_pkg::SW_IDLE; // [RULE_27]
				end
			end
			default: begin
				d.sw = mcc_pkg::SW_IDLE;
			end
		endcase

		// Main clock run gating per sleep mode.
		keep = {1'b0, q.xo_rstdby, q.lp_rstdby, q.fast_rstdby};
		case (sleep_mode_in)
			mcc_pkg::MODE_ACTIVE: d.main_run = 1'b1; // [RULE_04]
			mcc_pkg::MODE_IDLE: d.main_run = 1'b1; // [RULE_04]
			mcc_pkg::MODE_STANDBY:
				d.main_run = main_req_in || keep[q.cur]; // [RULE_04]
			default: d.main_run = nvm_busy_in; // [RULE_05]
		endcase

		// Peripheral requests routed to the chosen source.
		per_req[mcc_pkg::SRC_FAST] = tcd_enable_in && !tcd_src_in; // [RULE_02]
		per_req[mcc_pkg::SRC_LP] = (rtc_enable_in
			&& rtc_src_in == mcc_pkg::SRC_LP) // [RULE_22]
			|| wdt_enable_in || bod_sampled_in; // [RULE_22]
		per_req[mcc_pkg::SRC_XO] = rtc_enable_in
			&& rtc_src_in == mcc_pkg::SRC_XO; // [RULE_02]
		per_req[mcc_pkg::SRC_EXT] = (rtc_enable_in
			&& rtc_src_in == mcc_pkg::SRC_EXT)
			|| (tcd_enable_in && tcd_src_in); // [RULE_02]
		for (int s = 0; s < 4; s++) begin
			main_need[s] = (q.cur == 2'(s) && d.main_run)
				|| (q.sw == mcc_pkg::SW_BUSY && q.sel == 2'(s));
			d.osc_en[s] = main_need[s] || per_req[s] // [RULE_01]
				|| (keep[s] && sleep_mode_in != mcc_pkg::MODE_PDOWN); // [RULE_03]
		end
		d.osc_en[mcc_pkg::SRC_XO] = d.osc_en[mcc_pkg::SRC_XO]
			&& q.xo_en; // [RULE_21]

		// Fast oscillator held off for four cycles past synchronised ready.
		if (!q.osc_en[mcc_pkg::SRC_FAST] || !q.sync2[0]) begin
			d.fast_cnt = 3'h0;
		end else if (q.fast_cnt != mcc_pkg::FAST_EXTRA_CYC) begin
			d.fast_cnt = q.fast_cnt + 3'h1; // [RULE_19]
		end
		d.fast_gate = (d.fast_cnt == mcc_pkg::FAST_EXTRA_CYC)
			&& d.osc_en[mcc_pkg::SRC_FAST]; // [RULE_19]

		// External input counts edges before it is usable.
		if (!q.osc_en[mcc_pkg::SRC_EXT]) begin
			d.ext_cnt = 2'h0;
		end else if (q.sync2[3] != q.ext_prev
			&& q.ext_cnt != mcc_pkg::EXT_START_EDGES) begin
			d.ext_cnt = q.ext_cnt + 2'h1; // [RULE_26] [RULE_07]
		end

		// Prescaler; a new divisor takes effect at a tick boundary.
		d.per_tick = 1'b0;
		if (q.main_run) begin
			if (q.div_cnt + 7'h01 >= q.div_act) begin
				d.per_tick = 1'b1; // [RULE_11]
				d.div_cnt = 7'h00;
				d.div_act = div_new; // [RULE_28]
			end else begin
				d.div_cnt = q.div_cnt + 7'h01;
			end
		end
		d.clock_output_pin_on = q.clock_output_pin && q.main_run;

		// Read data, valid in the cycle after the strobe.
		d.rdata = 8'h00;
		if (rd_in) begin
			case (addr_in)
				mcc_pkg::OFS_CTRL_A: d.rdata = {q.clock_output_pin, 5'h00, q.sel};
				mcc_pkg::OFS_CTRL_B: d.rdata = {3'h0, q.pdiv, q.pen};
				mcc_pkg::OFS_LOCK: d.rdata = {7'h00, q.calibration_lock_enable};
				mcc_pkg::OFS_STATUS: begin
					d.rdata[mcc_pkg::BIT_EXT_S] =
						src_ok[mcc_pkg::SRC_EXT]; // [RULE_09]
					d.rdata[mcc_pkg::BIT_XO_S] = src_ok[mcc_pkg::SRC_XO];
					d.rdata[mcc_pkg::BIT_LP_S] = src_ok[mcc_pkg::SRC_LP];
					d.rdata[mcc_pkg::BIT_FAST_S] =
						src_ok[mcc_pkg::SRC_FAST];
					d.rdata[mcc_pkg::BIT_CHG] =
						(q.sw == mcc_pkg::SW_BUSY); // [RULE_08]
				end
				mcc_pkg::OFS_FAST_CTRL: d.rdata = {6'h00, q.fast_rstdby, 1'b0};
				mcc_pkg::OFS_CAL_A: d.rdata = {2'h0, q.cal};
				mcc_pkg::OFS_CAL_B: d.rdata = {q.lock_fuse, 3'h0, q.temp};
				mcc_pkg::OFS_LP_CTRL: d.rdata = {6'h00, q.lp_rstdby, 1'b0};
				mcc_pkg::OFS_XO_CTRL: d.rdata = {2'h0, q.xo_csut, 1'b0,
					q.xo_sel, q.xo_rstdby, q.xo_en};
				default: d.rdata = 8'h00;
			endcase
		end

		// Reset values; fuse fields captured while reset is held.
		if (srst_in) begin
			d = '0;
			d.sw = mcc_pkg::SW_IDLE;
			d.sel = mcc_pkg::SRC_FAST; // [RULE_13]
			d.cur = mcc_pkg::SRC_FAST; // [RULE_13]
			d.pdiv = mcc_pkg::RST_PDIV; // [RULE_13]
			d.pen = mcc_pkg::RST_PEN;
			d.div_act = mcc_pkg::RST_DIV; // [RULE_13]
			d.freq20 = fuse_freq20_in; // [RULE_14]
			d.lock_fuse = fuse_osc_lock_in; // [RULE_16]
			d.cal = fuse_cal_in; // [RULE_15]
			d.temp = fuse_temp_in; // [RULE_15]
		end
	end

	// ************************************************************
	// State register.
	// ************************************************************
	always_ff @(posedge clk_sys_in) begin
		q <= d;
	end

	assign rdata_out = q.rdata;
	assign osc_en_out = q.osc_en;
	assign fast_gate_out = q.fast_gate;
	assign main_src_out = q.cur;
	assign main_run_out = q.main_run;
	assign per_tick_out = q.per_tick;
	assign clock_output_pin_en_out = q.clock_output_pin_on;
	assign freq20_out = q.freq20;
	assign cal_out = q.cal;
	assign temp_out = q.temp;

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (srst_in);

	a_guard_closed_hold: assert property ( // [RULE_12]
		wr_in && q.guard == 3'h0 && addr_in == mcc_pkg::OFS_CTRL_B
		|=> $stable(q.pdiv) && $stable(q.pen))
		else $error("Prescaler changed without unlock.");
	a_guard_window_len: assert property ( // [RULE_24]
		guard_key_in ##1 !guard_key_in [*4] |=> q.guard == 3'h0)
		else $error("Guard window not four cycles.");
	a_reset_div_six: assert property ( // [RULE_13]
		$fell(srst_in) |-> q.div_act == mcc_pkg::RST_DIV
			&& q.cur == mcc_pkg::SRC_FAST)
		else $error("Reset did not select fast source at six.");
	a_switch_flag: assert property ( // [RULE_08]
		q.sw == mcc_pkg::SW_BUSY |=> $changed(q.cur) || q.sw == mcc_pkg::SW_BUSY)
		else $error("Switch flag dropped without switching.");
	a_switch_ready: assert property ( // [RULE_07]
		$changed(q.cur) |-> $past(sw_ok) && $past(q.sw) == mcc_pkg::SW_BUSY)
		else $error("Source switched before target ready.");
	a_pdown_stop: assert property ( // [RULE_05]
		sleep_mode_in == mcc_pkg::MODE_PDOWN && !nvm_busy_in |=> !q.main_run)
		else $error("Main clock ran on in power-down.");
	a_active_run: assert property ( // [RULE_04]
		sleep_mode_in == mcc_pkg::MODE_ACTIVE |=> q.main_run)
		else $error("Main clock stopped in active mode.");
	a_fast_holdoff: assert property ( // [RULE_19]
		$rose(fast_gate_out) |-> $past(q.sync2[0], 4))
		else $error("Fast output released early.");
	a_crystal_enable: assert property ( // [RULE_21]
		q.osc_en[mcc_pkg::SRC_XO] |-> $past(q.xo_en))
		else $error("Crystal ran without enable.");
	a_cal_locked: assert property ( // [RULE_16]
		q.lock_fuse |=> $stable(q.cal) && $stable(q.temp))
		else $error("Calibration changed while fuse locked.");
	a_tick_spacing: assert property ( // [RULE_28]
		q.per_tick && q.div_act == mcc_pkg::RST_DIV && q.main_run
		##1 q.main_run [*5]
		|=> q.per_tick)
		else $error("Tick spacing wrong.");
	a_tick_gap: assert property ( // [RULE_10]
		q.per_tick && q.div_act != 7'h01 |=> !q.per_tick)
		else $error("Back-to-back ticks with divisor above one.");
	a_cal_guard: assert property ( // [RULE_18]
		wr_in && !guard_open && addr_in == mcc_pkg::OFS_CAL_A |=> $stable(q.cal))
		else $error("Calibration changed without unlock.");
	a_ext_edges: assert property ( // [RULE_26]
		q.sw == mcc_pkg::SW_BUSY && q.sel == mcc_pkg::SRC_EXT
		&& q.ext_cnt != mcc_pkg::EXT_START_EDGES |=> q.cur != mcc_pkg::SRC_EXT)
		else $error("External source taken before enough edges.");

	c_switch_lp: cover property (q.sw == mcc_pkg::SW_BUSY
		##[1:20] q.cur == mcc_pkg::SRC_LP);
	c_standby_stop: cover property (sleep_mode_in == mcc_pkg::MODE_STANDBY
		##1 !q.main_run);
	c_cal_write: cover property (wr_in && guard_open
		&& addr_in == mcc_pkg::OFS_CAL_A ##1 $changed(q.cal));
	c_ext_ready: cover property ($rose(src_ok[mcc_pkg::SRC_EXT]));
	c_switch_ext: cover property (q.sw == mcc_pkg::SW_BUSY
		&& q.sel == mcc_pkg::SRC_EXT ##[1:200] q.cur == mcc_pkg::SRC_EXT);

endmodule

`default_nettype wire

// >>> testbench/mcc_far_side.sv
/*
 * Far-side model: the three oscillators and the external clock source.
 * Assumes the enables come from the controller on the system clock.
 */
`default_nettype none

module mcc_far_side #(
	parameter logic [3:0] START = 4'h8
) (
	input wire logic clk_in,
	input wire logic [3:0] osc_en_in,
	input wire logic ext_run_in,
	output logic [2:0] osc_ready_out,
	output logic ext_clk_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****
	// Oscillators.
	// ****
	logic [3:0] cnt_q [3] = '{default: 4'h0};

	// Ready follows the enable after a start-up time and drops at once.
	always_ff @(posedge clk_in) begin
		for (int k = 0; k < 3; k++) begin
			if (!osc_en_in[k])
				cnt_q[k] <= 4'h0;
			else if (cnt_q[k] != START)
				cnt_q[k] <= cnt_q[k] + 4'h1;
		end
	end

	always_comb begin
		for (int k = 0; k < 3; k++)
			osc_ready_out[k] = (cnt_q[k] == START);
	end

	// The external clock runs only when commanded and enabled.
	initial begin
		ext_clk_out = 1'b0;
		forever #70 if (ext_run_in && osc_en_in[3]) ext_clk_out = ~ext_clk_out;
	end
endmodule

`default_nettype wire

// >>> testbench/mcc_main_clock_controller_test.sv
/*
 * Self-checking bench: register access, guard window, prescaler, sleep,
 * requests, source switching and calibration of the clock controller.
 * Assumes the far-side model drives oscillator ready and external clock.
 */
`default_nettype none

module mcc_main_clock_controller_test;
	timeunit 1ns;
	timeprecision 1ns;

	// ****
	// Signals and instances.
	// ****
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0, rd_in = 1'b0, guard_key_in = 1'b0;
	logic [1:0] sleep_mode_in = 2'h0;
	logic main_req_in = 1'b0, nvm_busy_in = 1'b0, rtc_enable_in = 1'b0;
	logic [1:0] rtc_src_in = 2'h1;
	logic wdt_enable_in = 1'b0, bod_sampled_in = 1'b0, tcd_enable_in = 1'b0;
	logic tcd_src_in = 1'b0, fuse_freq20_in = 1'b1, fuse_osc_lock_in = 1'b0;
	logic [5:0] fuse_cal_in = 6'h1b;
	logic [3:0] fuse_temp_in = 4'h9;
	logic ext_run = 1'b0;
	logic [2:0] osc_ready_in;
	logic ext_clk_in, fast_gate_out, main_run_out, per_tick_out;
	logic clock_output_pin_en_out, freq20_out;
	logic [7:0] rdata_out, rv;
	logic [3:0] osc_en_out, temp_out;
	logic [1:0] main_src_out;
	logic [5:0] cal_out;
	int errors = 0;
	int comparisons = 0;
	int n;

	mcc_main_clock_controller i_mcc_main_clock_controller (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .guard_key_in(guard_key_in),
		.sleep_mode_in(sleep_mode_in), .main_req_in(main_req_in),
		.nvm_busy_in(nvm_busy_in), .rtc_enable_in(rtc_enable_in),
		.rtc_src_in(rtc_src_in), .wdt_enable_in(wdt_enable_in),
		.bod_sampled_in(bod_sampled_in), .tcd_enable_in(tcd_enable_in),
		.tcd_src_in(tcd_src_in), .fuse_freq20_in(fuse_freq20_in),
		.fuse_osc_lock_in(fuse_osc_lock_in), .fuse_cal_in(fuse_cal_in),
		.fuse_temp_in(fuse_temp_in), .osc_ready_in(osc_ready_in),
		.ext_clk_in(ext_clk_in), .osc_en_out(osc_en_out),
		.fast_gate_out(fast_gate_out), .main_src_out(main_src_out),
		.main_run_out(main_run_out), .per_tick_out(per_tick_out),
		.clock_output_pin_en_out(clock_output_pin_en_out), .freq20_out(freq20_out),
		.cal_out(cal_out), .temp_out(temp_out)
	);

	mcc_far_side i_mcc_far_side (
		.clk_in(clk_sys_in), .osc_en_in(osc_en_out), .ext_run_in(ext_run),
		.osc_ready_out(osc_ready_in), .ext_clk_out(ext_clk_in)
	);

	always #25 clk_sys_in = ~clk_sys_in;

	// ****
	// Bus and checking tasks.
	// ****
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	// Key pulse, then the write after the given number of idle cycles.
	task automatic gwr(input logic [7:0] a, input logic [7:0] d,
		input int gap = 0);
		guard_key_in <= 1'b1;
		@(posedge clk_sys_in);
		guard_key_in <= 1'b0;
		repeat (gap) @(posedge clk_sys_in);
		wr(a, d);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata_out;
		@(posedge clk_sys_in);
	endtask

	task automatic wait_src(input logic [1:0] s);
		for (int i = 0; i < 300 && main_src_out !== s; i++)
			@(posedge clk_sys_in);
	endtask

	// Cycles from one peripheral tick to the next.
	task automatic gap(output int g);
		int i;
		i = 0;
		do begin
			@(negedge clk_sys_in);
			i++;
		end while (per_tick_out !== 1'b1 && i < 300);
		g = 0;
		do begin
			@(negedge clk_sys_in);
			g++;
		end while (per_tick_out !== 1'b1 && g < 300);
		@(posedge clk_sys_in);
	endtask

	task automatic do_reset;
		srst_in <= 1'b1;
		repeat (10) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#2000000;
		errors++;
		report_and_stop();
	end

	// ****
	// Tests.
	// ****
	initial begin
		static int divs [12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 1};
		static logic [3:0] codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
			4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h0};
		do_reset();
		n = 0;
		while (fast_gate_out !== 1'b1 && n < 300) begin
			@(negedge clk_sys_in);
			n += osc_ready_in[0];
		end
		chk("gate_delay", 8'h1, {7'h0, n >= 4 && n <= 8});
		@(posedge clk_sys_in);
		chk("src_reset", mcc_pkg::SRC_FAST, main_src_out);
		rd(mcc_pkg::OFS_CTRL_B, rv);
		chk("ctrl_b", {3'h0, mcc_pkg::RST_PDIV, mcc_pkg::RST_PEN}, rv);
		chk("freq20", fuse_freq20_in, freq20_out);
		chk("cal", fuse_cal_in, cal_out);
		chk("temp", fuse_temp_in, temp_out);
		wr(mcc_pkg::OFS_CTRL_B, 8'h00);
		rd(mcc_pkg::OFS_CTRL_B, rv);
		chk("unguarded", 8'h11, rv);
		gwr(mcc_pkg::OFS_CTRL_B, 8'h03, 4);
		rd(mcc_pkg::OFS_CTRL_B, rv);
		chk("late_write", 8'h11, rv);
		gwr(mcc_pkg::OFS_CTRL_B, 8'h03, 3);
		rd(mcc_pkg::OFS_CTRL_B, rv);
		chk("last_slot", 8'h03, rv);
		for (int k = 0; k < 12; k++) begin
			gwr(mcc_pkg::OFS_CTRL_B, {3'h0, codes[k], k < 11});
			gap(n);
			gap(n);
			chk("tick_gap", divs[k][7:0], n[7:0]);
		end
		gwr(mcc_pkg::OFS_CTRL_B, 8'h0b);
		gwr(mcc_pkg::OFS_CAL_A, 8'h2a);
		repeat (4) @(posedge clk_sys_in);
		wr(mcc_pkg::OFS_CAL_A, 8'h01);
		chk("cal_guard", 8'h2a, cal_out);
		gwr(mcc_pkg::OFS_CAL_B, 8'h05);
		chk("temp_set", 8'h05, temp_out);
		gwr(mcc_pkg::OFS_LOCK, 8'h01);
		gwr(mcc_pkg::OFS_CAL_A, 8'h11);
		chk("cal_locked", 8'h2a, cal_out);
		sleep_mode_in <= mcc_pkg::MODE_IDLE;
		repeat (6) @(posedge clk_sys_in);
		chk("run_idle", 8'h1, main_run_out);
		sleep_mode_in <= mcc_pkg::MODE_STANDBY;
		repeat (6) @(posedge clk_sys_in);
		chk("run_stby", 8'h0, main_run_out);
		main_req_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		chk("run_req", 8'h1, main_run_out);
		main_req_in <= 1'b0;
		gwr(mcc_pkg::OFS_FAST_CTRL, 8'h02);
		repeat (20) @(posedge clk_sys_in);
		chk("run_rstdby", 8'h1, main_run_out);
		chk("gate_rstdby", 8'h1, fast_gate_out);
		nvm_busy_in <= 1'b1;
		sleep_mode_in <= mcc_pkg::MODE_PDOWN;
		repeat (6) @(posedge clk_sys_in);
		chk("run_nvm", 8'h1, main_run_out);
		nvm_busy_in <= 1'b0;
		repeat (6) @(posedge clk_sys_in);
		chk("run_pdown", 8'h0, main_run_out);
		chk("fast_pdown", 8'h0, osc_en_out[0]);
		sleep_mode_in <= mcc_pkg::MODE_ACTIVE;
		repeat (30) @(posedge clk_sys_in);
		gwr(mcc_pkg::OFS_FAST_CTRL, 8'h00);
		wdt_enable_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		chk("lp_wdt", 8'h1, osc_en_out[1]);
		wdt_enable_in <= 1'b0;
		bod_sampled_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		chk("lp_bod", 8'h1, osc_en_out[1]);
		bod_sampled_in <= 1'b0;
		rtc_src_in <= 2'h2;
		repeat (6) @(posedge clk_sys_in);
		chk("lp_off", 8'h0, osc_en_out[1]);
		rtc_enable_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		chk("xo_off", 8'h0, osc_en_out[2]);
		gwr(mcc_pkg::OFS_XO_CTRL, 8'h01);
		repeat (20) @(posedge clk_sys_in);
		chk("xo_rtc", 8'h1, osc_en_out[2]);
		rd(mcc_pkg::OFS_STATUS, rv);
		chk("xo_stable", 8'h1, rv[mcc_pkg::BIT_XO_S]);
		rtc_enable_in <= 1'b0;
		tcd_src_in <= 1'b1;
		@(posedge clk_sys_in);
		rtc_src_in <= 2'h1;
		tcd_enable_in <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
		chk("ext_tcd", 8'h1, osc_en_out[3]);
		tcd_enable_in <= 1'b0;
		gwr(mcc_pkg::OFS_CTRL_A, 8'h80);
		repeat (4) @(posedge clk_sys_in);
		chk("clock_output_pin", 8'h1, clock_output_pin_en_out);
		gwr(mcc_pkg::OFS_CTRL_A, {6'h0, mcc_pkg::SRC_LP});
		rd(mcc_pkg::OFS_STATUS, rv);
		chk("changing", 8'h1, rv[mcc_pkg::BIT_CHG]);
		wait_src(mcc_pkg::SRC_LP);
		chk("src_lp", mcc_pkg::SRC_LP, main_src_out);
		rd(mcc_pkg::OFS_STATUS, rv);
		chk("changed", 8'h0, rv[mcc_pkg::BIT_CHG]);
		chk("lp_stable", 8'h1, rv[mcc_pkg::BIT_LP_S]);
		chk("fast_off", 8'h0, osc_en_out[0]);
		gwr(mcc_pkg::OFS_CAL_A, 8'h11);
		chk("cal_free", 8'h11, cal_out);
		gwr(mcc_pkg::OFS_CTRL_A, {6'h0, mcc_pkg::SRC_EXT});
		repeat (40) @(posedge clk_sys_in);
		chk("ext_wait", mcc_pkg::SRC_LP, main_src_out);
		gwr(mcc_pkg::OFS_CTRL_A, {6'h0, mcc_pkg::SRC_FAST});
		repeat (40) @(posedge clk_sys_in);
		chk("frozen", mcc_pkg::SRC_LP, main_src_out);
		rd(mcc_pkg::OFS_STATUS, rv);
		chk("pending", 8'h1, rv[mcc_pkg::BIT_CHG]);
		ext_run <= 1'b1;
		wait_src(mcc_pkg::SRC_EXT);
		chk("src_ext", mcc_pkg::SRC_EXT, main_src_out);
		rd(mcc_pkg::OFS_STATUS, rv);
		chk("ext_stable", 8'h1, rv[mcc_pkg::BIT_EXT_S]);
		fuse_osc_lock_in <= 1'b1;
		fuse_freq20_in <= 1'b0;
		fuse_cal_in <= 6'h05;
		do_reset();
		repeat (30) @(posedge clk_sys_in);
		chk("src_again", mcc_pkg::SRC_FAST, main_src_out);
		chk("freq16", 8'h0, freq20_out);
		chk("cal_fuse", 8'h05, cal_out);
		gwr(mcc_pkg::OFS_CAL_A, 8'h3c);
		chk("cal_fused", 8'h05, cal_out);
		rd(mcc_pkg::OFS_CAL_B, rv);
		chk("lock_bit", 8'h1, rv[7]);
		report_and_stop();
	end
endmodule

`default_nettype wire
